// ==== hdl/shd_pkg.sv ====
`default_nettype none
package shd_pkg;
	// Health code layout: MSB-numbered bits 0..2 are data health, 3..7 signal health
	localparam int SHD_DIGIT_W = 4;
	localparam int SHD_CODE_W = 8;
	localparam int SHD_DATA_W = 3;
	localparam int SHD_SIG_W = 5;
	localparam int SHD_DATA_LSB = 5;
	// Signal health code boundaries
	localparam logic [4:0] SHD_SIG_ALL_LAST = 5'h03;
	localparam logic [4:0] SHD_SIG_PAIR_FIRST = 5'h10;
	localparam logic [4:0] SHD_SIG_SV_OUT = 5'h1c;
	localparam logic [4:0] SHD_SIG_SV_SOON = 5'h1d;
	localparam logic [4:0] SHD_SIG_SPARE = 5'h1e;
	localparam logic [4:0] SHD_SIG_MULTI = 5'h1f;
	// First code of the per-signal triples, and the length of one triple
	localparam logic [4:0] SHD_SIG_TRIPLE_FIRST = 5'h04;
	localparam logic [4:0] SHD_TRIPLE_LEN = 5'h03;
	// Failing-test index shown on the fail-step pins, in run order
	localparam logic [1:0] SHD_FAIL_PROG = 2'h0;
	localparam logic [1:0] SHD_FAIL_RAM = 2'h1;
	localparam logic [1:0] SHD_FAIL_MAGV = 2'h2;
	localparam logic [1:0] SHD_FAIL_CHAN = 2'h3;
	// Confirmation window: 10 s at 10 MHz
	localparam longint SHD_CONFIRM_S = 10;
	localparam longint SHD_CLK_HZ = 10000000;
	localparam longint SHD_CONFIRM_CYC = SHD_CONFIRM_S * SHD_CLK_HZ;
	localparam int SHD_TMR_W = 27;

	typedef enum logic [2:0] {
		SHD_DH_GOOD = 3'h0,
		SHD_DH_PARITY = 3'h1,
		SHD_DH_TLM_HOW = 3'h2,
		SHD_DH_ZCOUNT = 3'h3,
		SHD_DH_SF123 = 3'h4,
		SHD_DH_SF45 = 3'h5,
		SHD_DH_UPLOAD = 3'h6,
		SHD_DH_ALL_BAD = 3'h7
	} shd_data_e;

	typedef enum logic [3:0] {
		SHD_GRP_ALL = 4'h0,
		SHD_GRP_L1P = 4'h1,
		SHD_GRP_L2P = 4'h2,
		SHD_GRP_L1C = 4'h3,
		SHD_GRP_L2C = 4'h4,
		SHD_GRP_L1P_L2P = 4'h5,
		SHD_GRP_L1C_L2C = 4'h6,
		SHD_GRP_L1 = 4'h7,
		SHD_GRP_L2 = 4'h8,
		SHD_GRP_NONE = 4'h9
	} shd_grp_e;

	typedef enum logic [2:0] {
		SHD_CO_GOOD = 3'h0,
		SHD_CO_WEAK = 3'h1,
		SHD_CO_DEAD = 3'h2,
		SHD_CO_NOMOD = 3'h3,
		SHD_CO_SV_OUT = 3'h4,
		SHD_CO_SV_SOON = 3'h5,
		SHD_CO_SPARE = 3'h6,
		SHD_CO_MULTI = 3'h7
	} shd_cond_e;

	typedef struct packed {
		shd_data_e data;
		shd_grp_e grp;
		shd_cond_e cond;
		logic [4:0] sig_raw;
	} shd_health_s;

	// Self-test results, in the order they are run
	typedef struct packed {
		logic prog_sum_ok;
		logic external_ram_present;
		logic magvar_sum_ok;
		logic chan_load_ok;
	} shd_test_s;

	typedef enum logic [3:0] {
		SHD_ST_IDLE = 4'h0,
		SHD_ST_PROG = 4'h1,
		SHD_ST_RAM_CHK = 4'h3,
		SHD_ST_MAGV = 4'h2,
		SHD_ST_CHAN = 4'h6,
		SHD_ST_MAIN = 4'h7,
		SHD_ST_HALT = 4'h5,
		SHD_ST_ASK = 4'h4,
		SHD_ST_CLEAR = 4'hc,
		SHD_ST_DONE = 4'hd
	} shd_state_e;

	typedef enum logic [1:0] {
		SHD_MSG_NONE = 2'h0,
		SHD_MSG_INT = 2'h1,
		SHD_MSG_EXT = 2'h2
	} shd_clr_e;
endpackage
`default_nettype wire

// ==== hdl/shd_decode.sv ====
`default_nettype none
module shd_decode (
	input wire logic [shd_pkg::SHD_CODE_W-1:0] code,
	output shd_pkg::shd_health_s health
);
	import shd_pkg::*;
	logic [SHD_SIG_W-1:0] sig;
	logic [SHD_SIG_W-1:0] off;
	// Field split; top three bits are data health
	always_comb begin
		sig = code[SHD_SIG_W-1:0];
		health.data = shd_data_e'(code[SHD_CODE_W-1:SHD_DATA_LSB]);
		health.sig_raw = sig;
		off = 5'h0;
		health.grp = SHD_GRP_NONE;
		health.cond = SHD_CO_GOOD;
		if (sig <= SHD_SIG_ALL_LAST) begin
			health.grp = SHD_GRP_ALL;
			health.cond = shd_cond_e'(sig[2:0]);
		end else if (sig < SHD_SIG_SV_OUT) begin
			// Triples of weak, dead, no modulation from code 4 upward
			off = sig - SHD_SIG_TRIPLE_FIRST;
			health.grp = shd_grp_e'(4'(off / SHD_TRIPLE_LEN) + SHD_GRP_L1P);
			health.cond = shd_cond_e'(3'(off % SHD_TRIPLE_LEN) + SHD_CO_WEAK);
		end else begin
			health.grp = SHD_GRP_NONE;
			unique case (sig)
				SHD_SIG_SV_OUT: health.cond = SHD_CO_SV_OUT;
				SHD_SIG_SV_SOON: health.cond = SHD_CO_SV_SOON;
				SHD_SIG_SPARE: health.cond = SHD_CO_SPARE;
				default: health.cond = SHD_CO_MULTI;
			endcase
		end
	end
endmodule // shd_decode
`default_nettype wire

// ==== hdl/shd_timer.sv ====
`default_nettype none
module shd_timer #(
	parameter longint LIMIT = 100
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic start,
	output logic expired
);
	import shd_pkg::*;
	logic [SHD_TMR_W-1:0] cnt_q, cnt_d;
	logic run_q, run_d;
	// Counts from start; expired is a one-cycle pulse when the window ends
	always_comb begin
		cnt_d = cnt_q;
		run_d = run_q;
		expired = 1'b0;
		if (start) begin
			cnt_d = '0;
			run_d = 1'b1;
		end else if (run_q) begin
			if (cnt_q == SHD_TMR_W'(LIMIT - 1)) begin
				expired = 1'b1;
				run_d = 1'b0;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			run_q <= run_d;
		end
	end
endmodule // shd_timer
`default_nettype wire

// ==== hdl/shd_top.sv ====
`default_nettype none
module shd_top #(
	parameter longint CONFIRM_CYC = shd_pkg::SHD_CONFIRM_CYC
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic [shd_pkg::SHD_DIGIT_W-1:0] DIGIT_HI,
	input wire logic [shd_pkg::SHD_DIGIT_W-1:0] DIGIT_LO,
	input wire logic CODE_VALID,
	output shd_pkg::shd_health_s HEALTH,
	output logic HEALTH_VALID,
	input wire logic KEY_UP,
	input wire logic KEY_RIGHT,
	input wire logic KEY_YES,
	input wire logic KEY_ANY,
	output logic TEST_REQ,
	input wire logic TEST_DONE,
	input wire shd_pkg::shd_test_s TEST_RESULT,
	output shd_pkg::shd_state_e STATE,
	output logic [1:0] FAIL_STEP,
	output logic HALTED,
	output logic MAIN_READY,
	output shd_pkg::shd_clr_e PROMPT,
	output logic CLEAR_INT,
	output logic CLEAR_EXT
);
	import shd_pkg::*;

	logic [SHD_CODE_W-1:0] code;
	shd_health_s dec;
	shd_health_s health_q, health_d;
	logic hv_q, hv_d;
	logic tmr_start, tmr_exp;

	// Join digits, first digit high
	assign code = {DIGIT_HI, DIGIT_LO};

	shd_decode u_dec (
		.code(code),
		.health(dec)
	);

	// Decoded result captured one edge after the code, held otherwise
	always_comb begin
		health_d = health_q;
		hv_d = hv_q;
		if (CODE_VALID) begin
			health_d = dec;
			hv_d = 1'b1;
		end
	end
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			health_q <= '0;
			hv_q <= 1'b0;
		end else begin
			health_q <= health_d;
			hv_q <= hv_d;
		end
	end
	assign HEALTH = health_q;
	assign HEALTH_VALID = hv_q;

	shd_timer #(
		.LIMIT(CONFIRM_CYC)
	) u_tmr (
		.clk(CLK),
		.reset_n(RESET_N),
		.start(tmr_start),
		.expired(tmr_exp)
	);

	shd_state_e st_q, st_d;
	logic [1:0] fail_q, fail_d;
	shd_clr_e mode_q, mode_d;
	logic req_q, req_d;
	logic ci_q, ci_d;
	logic ce_q, ce_d;
	logic first_q, first_d;
	// Status flags kept in flops of their own
	logic halt_q, halt_d;
	logic main_q, main_d;

	// Power-up sequence; keys are sampled on the first cycle after reset
	always_comb begin
		st_d = st_q;
		fail_d = fail_q;
		mode_d = mode_q;
		req_d = 1'b0;
		ci_d = 1'b0;
		ce_d = 1'b0;
		first_d = 1'b0;
		tmr_start = 1'b0;
		unique case (st_q)
			SHD_ST_IDLE: begin
				if (first_q && KEY_UP) begin
					st_d = SHD_ST_ASK;
					mode_d = SHD_MSG_INT;
					tmr_start = 1'b1;
				end else if (first_q && KEY_RIGHT) begin
					st_d = SHD_ST_ASK;
					mode_d = SHD_MSG_EXT;
					tmr_start = 1'b1;
				end else begin
					st_d = SHD_ST_PROG;
					req_d = 1'b1;
				end
			end
			SHD_ST_ASK: begin
				// No yes in time: skip the clear and go on to self-test
				if (KEY_YES) begin
					st_d = SHD_ST_CLEAR;
					ci_d = (mode_q == SHD_MSG_INT);
					ce_d = (mode_q == SHD_MSG_EXT);
				end else if (tmr_exp) begin
					st_d = SHD_ST_PROG;
					mode_d = SHD_MSG_NONE;
					req_d = 1'b1;
				end
			end
			SHD_ST_CLEAR: begin
				// Waits for release of the yes key so it is not taken as any key
				if (!KEY_YES && !KEY_ANY) begin
					st_d = SHD_ST_DONE;
				end
			end
			SHD_ST_DONE: begin
				if (KEY_ANY) begin
					st_d = SHD_ST_PROG;
					mode_d = SHD_MSG_NONE;
					req_d = 1'b1;
				end
			end
			SHD_ST_PROG: begin
				if (TEST_DONE) begin
					if (TEST_RESULT.prog_sum_ok) begin
						st_d = SHD_ST_RAM_CHK;
					end else begin
						st_d = SHD_ST_HALT;
						fail_d = SHD_FAIL_PROG;
					end
				end
			end
			SHD_ST_RAM_CHK: begin
				if (TEST_DONE) begin
					if (TEST_RESULT.external_ram_present) begin
						st_d = SHD_ST_MAGV;
					end else begin
						st_d = SHD_ST_HALT;
						fail_d = SHD_FAIL_RAM;
					end
				end
			end
			SHD_ST_MAGV: begin
				if (TEST_DONE) begin
					if (TEST_RESULT.magvar_sum_ok) begin
						st_d = SHD_ST_CHAN;
					end else begin
						st_d = SHD_ST_HALT;
						fail_d = SHD_FAIL_MAGV;
					end
				end
			end
			SHD_ST_CHAN: begin
				if (TEST_DONE) begin
					if (TEST_RESULT.chan_load_ok) begin
						st_d = SHD_ST_MAIN;
					end else begin
						st_d = SHD_ST_HALT;
						fail_d = SHD_FAIL_CHAN;
					end
				end
			end
			SHD_ST_MAIN: st_d = SHD_ST_MAIN;
			SHD_ST_HALT: st_d = SHD_ST_HALT;
			default: st_d = SHD_ST_HALT;
		endcase
		// Flags follow the next state, so the pins match the state code
		halt_d = (st_d == SHD_ST_HALT);
		main_d = (st_d == SHD_ST_MAIN);
	end
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st_q <= SHD_ST_IDLE;
			fail_q <= 2'h0;
			mode_q <= SHD_MSG_NONE;
			req_q <= 1'b0;
			ci_q <= 1'b0;
			ce_q <= 1'b0;
			first_q <= 1'b1;
			halt_q <= 1'b0;
			main_q <= 1'b0;
		end else begin
			st_q <= st_d;
			fail_q <= fail_d;
			mode_q <= mode_d;
			req_q <= req_d;
			ci_q <= ci_d;
			ce_q <= ce_d;
			first_q <= first_d;
			halt_q <= halt_d;
			main_q <= main_d;
		end
	end
	// Pins straight from flops; no decode glitches reach the panel
	assign STATE = st_q;
	assign FAIL_STEP = fail_q;
	assign HALTED = halt_q;
	assign MAIN_READY = main_q;
	assign PROMPT = mode_q;
	assign TEST_REQ = req_q;
	assign CLEAR_INT = ci_q;
	assign CLEAR_EXT = ce_q;

	// Checks
	sequence code_in_s;
		CODE_VALID;
	endsequence
	property dec_reg_p;
		@(posedge CLK) disable iff (!RESET_N) code_in_s |=> (HEALTH == $past(dec));
	endproperty
	dec_latency_a: assert property (dec_reg_p) else $error("decode not registered");
	hold_value_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		!CODE_VALID |=> $stable(HEALTH)) else $error("health changed without code");
	data_field_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		CODE_VALID |=> HEALTH.data == $past(DIGIT_HI[3:1])) else $error("data field wrong");
	sig_field_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		CODE_VALID |=> HEALTH.sig_raw == $past({DIGIT_HI[0], DIGIT_LO}))
		else $error("signal field wrong");
	all_group_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		CODE_VALID && DIGIT_HI[0] == 1'b0 && DIGIT_LO < 4'h4 |=> HEALTH.grp == SHD_GRP_ALL)
		else $error("all-signal group wrong");
	sv_out_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		CODE_VALID && {DIGIT_HI[0], DIGIT_LO} == SHD_SIG_SV_OUT |=> HEALTH.cond == SHD_CO_SV_OUT)
		else $error("sv out wrong");
	l2p_dead_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		CODE_VALID && {DIGIT_HI[0], DIGIT_LO} == 5'h08
		|=> HEALTH.grp == SHD_GRP_L2P && HEALTH.cond == SHD_CO_DEAD)
		else $error("L2P dead wrong");
	pair_weak_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		CODE_VALID && {DIGIT_HI[0], DIGIT_LO} == SHD_SIG_PAIR_FIRST
		|=> HEALTH.grp == SHD_GRP_L1P_L2P && HEALTH.cond == SHD_CO_WEAK)
		else $error("pair weak wrong");
	parity_code_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		CODE_VALID && DIGIT_HI[3:1] == 3'h1 |=> HEALTH.data == SHD_DH_PARITY)
		else $error("parity code wrong");
	allbad_code_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		CODE_VALID && DIGIT_HI[3:1] == 3'h7 |=> HEALTH.data == SHD_DH_ALL_BAD)
		else $error("all bad code wrong");
	halt_sticky_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		HALTED |=> HALTED && $stable(FAIL_STEP)) else $error("halt left");
	ram_fail_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		st_q == SHD_ST_RAM_CHK && TEST_DONE && !TEST_RESULT.external_ram_present
		|=> HALTED && FAIL_STEP == SHD_FAIL_RAM) else $error("ram fail not halted");
	int_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		st_q == SHD_ST_ASK && KEY_YES && mode_q == SHD_MSG_INT |=> CLEAR_INT && !CLEAR_EXT)
		else $error("internal clear missing");
	ext_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		st_q == SHD_ST_ASK && KEY_YES && mode_q == SHD_MSG_EXT |=> CLEAR_EXT && !CLEAR_INT)
		else $error("external clear missing");

	// Clear flow in steps: prompt, yes or timeout, then any key
	sequence ask_expire_s;
		st_q == SHD_ST_ASK && tmr_exp && !KEY_YES;
	endsequence
	sequence done_key_s;
		st_q == SHD_ST_DONE && KEY_ANY;
	endsequence
	ask_timeout_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		ask_expire_s |=> st_q == SHD_ST_PROG && TEST_REQ && !CLEAR_INT && !CLEAR_EXT)
		else $error("prompt timeout wrong");
	any_key_resume_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		done_key_s |=> st_q == SHD_ST_PROG && TEST_REQ && PROMPT == SHD_MSG_NONE)
		else $error("resume after clear wrong");
	// A held clear pulse would wipe memory more than once
	clear_one_shot_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		CLEAR_INT || CLEAR_EXT |=> !CLEAR_INT && !CLEAR_EXT)
		else $error("clear pulse too long");
	// Self-test start, order and end of the run
	boot_req_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		st_q == SHD_ST_IDLE && !(first_q && (KEY_UP || KEY_RIGHT))
		|=> st_q == SHD_ST_PROG && TEST_REQ) else $error("self-test not started");
	prog_pass_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		st_q == SHD_ST_PROG && TEST_DONE && TEST_RESULT.prog_sum_ok
		|=> st_q == SHD_ST_RAM_CHK) else $error("test order wrong");
	magv_fail_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		st_q == SHD_ST_MAGV && TEST_DONE && !TEST_RESULT.magvar_sum_ok
		|=> HALTED && FAIL_STEP == SHD_FAIL_MAGV) else $error("magvar fail not halted");
	chan_pass_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		st_q == SHD_ST_CHAN && TEST_DONE && TEST_RESULT.chan_load_ok
		|=> MAIN_READY && !HALTED) else $error("main screen not entered");
	halt_flag_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		HALTED == (st_q == SHD_ST_HALT) && MAIN_READY == (st_q == SHD_ST_MAIN))
		else $error("status flags out of step");
	valid_sticky_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		HEALTH_VALID |=> HEALTH_VALID) else $error("valid flag dropped");
endmodule // shd_top
`default_nettype wire

// ==== test/shd_panel_model.sv ====
`default_nettype none
// Self-test responder: answers each test state after DLY cycles
module shd_panel_model #(
	parameter int DLY = 3
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire shd_pkg::shd_state_e state,
	input wire logic fail_en,
	input wire logic [1:0] fail_idx,
	output logic test_done,
	output shd_pkg::shd_test_s test_result
);
	timeunit 1ns;
	timeprecision 100ps;
	import shd_pkg::*;
	int cnt_q;
	logic [1:0] idx;
	logic in_test;
	logic [3:0] good;
	// Test index from state, in run order
	always_comb begin
		in_test = 1'b1;
		idx = 2'h0;
		case (state)
			SHD_ST_PROG: idx = 2'h0;
			SHD_ST_RAM_CHK: idx = 2'h1;
			SHD_ST_MAGV: idx = 2'h2;
			SHD_ST_CHAN: idx = 2'h3;
			default: in_test = 1'b0;
		endcase
		good = fail_en && idx == fail_idx ? ~(4'h8 >> idx) : 4'hf;
		// Result only valid with the strobe; inverted otherwise
		test_result = shd_test_s'(test_done ? good : ~good);
	end
	// Strobe driven off the falling edge, like the bench
	always @(negedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 0;
			test_done <= 1'b0;
		end else if (test_done || !in_test) begin
			test_done <= 1'b0;
			cnt_q <= 0;
		end else if (cnt_q == DLY) begin
			test_done <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
endmodule // shd_panel_model
`default_nettype wire

// ==== test/testbench.sv ====
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import shd_pkg::*;
	localparam int CONF = 20;
	logic CLK, RESET_N, CODE_VALID, KEY_UP, KEY_RIGHT, KEY_YES, KEY_ANY;
	logic [3:0] DIGIT_HI, DIGIT_LO;
	logic TEST_REQ, TEST_DONE, HALTED, MAIN_READY, CLEAR_INT, CLEAR_EXT, fail_en;
	logic [1:0] FAIL_STEP, fail_idx;
	shd_health_s HEALTH;
	logic HEALTH_VALID;
	shd_test_s TEST_RESULT;
	shd_state_e STATE;
	shd_clr_e PROMPT;
	int n_fail = 0;
	int n_tests = 0;
	shd_state_e seen[$];
	shd_state_e order[5] = '{SHD_ST_PROG, SHD_ST_RAM_CHK, SHD_ST_MAGV, SHD_ST_CHAN,
		SHD_ST_MAIN};
	shd_top #(.CONFIRM_CYC(CONF)) i_dut (.CLK(CLK), .RESET_N(RESET_N), .DIGIT_HI(DIGIT_HI),
		.DIGIT_LO(DIGIT_LO), .CODE_VALID(CODE_VALID), .HEALTH(HEALTH),
		.HEALTH_VALID(HEALTH_VALID), .KEY_UP(KEY_UP), .KEY_RIGHT(KEY_RIGHT),
		.KEY_YES(KEY_YES), .KEY_ANY(KEY_ANY), .TEST_REQ(TEST_REQ), .TEST_DONE(TEST_DONE),
		.TEST_RESULT(TEST_RESULT), .STATE(STATE), .FAIL_STEP(FAIL_STEP), .HALTED(HALTED),
		.MAIN_READY(MAIN_READY), .PROMPT(PROMPT), .CLEAR_INT(CLEAR_INT),
		.CLEAR_EXT(CLEAR_EXT));
	shd_panel_model i_panel (.clk(CLK), .reset_n(RESET_N), .state(STATE), .fail_en(fail_en),
		.fail_idx(fail_idx), .test_done(TEST_DONE), .test_result(TEST_RESULT));
	// Clock, 100 ns period
	initial begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Keys must already be held when reset lets go
	task automatic do_reset(input logic up, input logic right);
		@(negedge CLK);
		RESET_N = 1'b0;
		KEY_UP = up;
		KEY_RIGHT = right;
		repeat (4) @(negedge CLK);
		RESET_N = 1'b1;
		@(negedge CLK);
		KEY_UP = 1'b0;
		KEY_RIGHT = 1'b0;
	endtask
	// Run to main or halt, logging states and clear pulses
	task automatic run_end(output int ci, output int ce);
		int i;
		ci = 0;
		ce = 0;
		seen.delete();
		seen.push_back(STATE);
		for (i = 0; i < 300 && MAIN_READY !== 1'b1 && HALTED !== 1'b1; i++) begin
			@(negedge CLK);
			ci += int'(CLEAR_INT === 1'b1);
			ce += int'(CLEAR_EXT === 1'b1);
			if (STATE !== seen[$]) seen.push_back(STATE);
		end
		if (i == 300) begin
			n_fail++;
			report_and_stop();
		end
	endtask
	task automatic check_order(input int off, input int n);
		check(seen.size(), off + n);
		for (int i = 0; i < n && off + i < seen.size(); i++) check(seen[off + i], order[i]);
	endtask
	// One code with the strobe for one cycle, result one edge later
	task automatic spot(input logic [7:0] c, input logic [14:0] e);
		{CODE_VALID, DIGIT_HI, DIGIT_LO} = {1'b1, c};
		@(negedge CLK);
		CODE_VALID = 1'b0;
		check(HEALTH, e);
	endtask
	// Every code back to back, then a hold with the strobe low
	task automatic t_decode();
		shd_health_s e;
		int s;
		int m;
		for (int c = 0; c < 257; c++) begin
			m = c < 256 ? c : 255;
			CODE_VALID = c < 256;
			{DIGIT_HI, DIGIT_LO} = c[7:0];
			s = m & 31;
			e.data = shd_data_e'(3'(m >> 5));
			e.sig_raw = 5'(s);
			if (s < 4) e = '{e.data, SHD_GRP_ALL, shd_cond_e'(3'(s)), e.sig_raw};
			else if (s < 28) e = '{e.data, shd_grp_e'(4'(1 + (s - 4) / 3)),
				shd_cond_e'(3'(1 + (s - 4) % 3)), e.sig_raw};
			else e = '{e.data, SHD_GRP_NONE, shd_cond_e'(3'(s - 24)), e.sig_raw};
			@(negedge CLK);
			check(HEALTH, e);
		end
		repeat (3) @(negedge CLK);
		check(HEALTH, e);
		check(HEALTH_VALID, 1);
		// Fixed examples spelled out, not computed
		spot(8'h3c, {SHD_DH_PARITY, SHD_GRP_NONE, SHD_CO_SV_OUT, 5'h1c});
		spot(8'h08, {SHD_DH_GOOD, SHD_GRP_L2P, SHD_CO_DEAD, 5'h08});
		spot(8'hf0, {SHD_DH_ALL_BAD, SHD_GRP_L1P_L2P, SHD_CO_WEAK, 5'h10});
	endtask
	task automatic t_pass();
		int ci, ce;
		do_reset(0, 0);
		check({HEALTH_VALID, HEALTH, CLEAR_INT, CLEAR_EXT}, 0);
		check(TEST_REQ, 1);
		run_end(ci, ce);
		check({HALTED, MAIN_READY}, 2'b01);
		check_order(0, 5);
	endtask
	task automatic t_fail(input int k);
		int ci, ce;
		fail_en = 1'b1;
		fail_idx = 2'(k);
		do_reset(0, 0);
		run_end(ci, ce);
		repeat (20) @(negedge CLK);
		check({HALTED, MAIN_READY, FAIL_STEP, STATE}, {2'b10, 2'(k), SHD_ST_HALT});
		check(seen.pop_back(), SHD_ST_HALT);
		check_order(0, k + 1);
		fail_en = 1'b0;
	endtask
	// Clear flow for one key; ext selects the right-hand key
	task automatic t_clear(input logic ext, input logic yes);
		int ci, ce;
		do_reset(!ext, ext);
		check({STATE, PROMPT}, {SHD_ST_ASK, ext ? SHD_MSG_EXT : SHD_MSG_INT});
		if (yes) begin
			KEY_YES = 1'b1;
			@(negedge CLK);
			KEY_YES = 1'b0;
			check({CLEAR_INT, CLEAR_EXT}, {!ext, ext});
			repeat (3) @(negedge CLK);
			check(STATE, SHD_ST_DONE);
			KEY_ANY = 1'b1;
			@(negedge CLK);
			KEY_ANY = 1'b0;
			check({STATE, TEST_REQ, PROMPT}, {SHD_ST_PROG, 1'b1, SHD_MSG_NONE});
		end else begin
			// Prompt lasts exactly the window, then self-test without a clear
			repeat (CONF - 1) @(negedge CLK);
			check(STATE, SHD_ST_ASK);
			@(negedge CLK);
			check({STATE, TEST_REQ, PROMPT}, {SHD_ST_PROG, 1'b1, SHD_MSG_NONE});
		end
		run_end(ci, ce);
		check(ci + ce, 0);
		check_order(0, 5);
	endtask
	initial begin
		{RESET_N, CODE_VALID, KEY_UP, KEY_RIGHT, KEY_YES, KEY_ANY, fail_en} = '0;
		{DIGIT_HI, DIGIT_LO, fail_idx} = '0;
		do_reset(0, 0);
		t_decode();
		t_pass();
		for (int k = 0; k < 4; k++) t_fail(k);
		t_clear(0, 1);
		t_clear(1, 1);
		t_clear(0, 0);
		t_clear(1, 0);
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
